// ### design/pfdc_forced_duty.sv
`timescale 1ns/1ps

module pfdc_forced_duty #(
  parameter int CNT_W = pfdc_pkg::CNT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [pfdc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pfdc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pfdc_pkg::DATA_W-1:0] regRdData,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic underflow_irq,
  output logic irq
);

  // ************************************************************
  // block state
  // ************************************************************
  typedef struct packed {
    logic runReq;
    logic running;
    logic countDown;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] period;
    logic [pfdc_pkg::NUM_OUT-1:0][CNT_W-1:0] cmp;
    logic [pfdc_pkg::NUM_OUT-1:0] stopLevel;
    logic [pfdc_pkg::NUM_OUT-1:0][1:0] forceSel;
    logic [pfdc_pkg::NUM_OUT-1:0] reflect;
    logic [pfdc_pkg::IRQ_W-1:0] irqStat;
    logic [pfdc_pkg::IRQ_W-1:0] irqMask;
    logic irq;
    logic underflowPulse;
    logic [pfdc_pkg::DATA_W-1:0] rdData;
  } pfdc_state_s;

  pfdc_state_s st_reg;
  pfdc_state_s st_next;

  // ************************************************************
  // events of the current cycle
  // ************************************************************
  logic startNow;
  logic underflowNow;
  logic [pfdc_pkg::NUM_OUT-1:0] matchNow;
  logic [pfdc_pkg::NUM_OUT-1:0] pinLevel;
  logic [pfdc_pkg::NUM_OUT-1:0][1:0] activeForce;
  pfdc_pkg::pfdc_chan_cfg_s [pfdc_pkg::NUM_OUT-1:0] chanCfg;

  // counting begins the cycle after the run request is seen
  assign startNow = st_reg.runReq && !st_reg.running;

  // bottom of the falling slope closes the carrier cycle
  assign underflowNow = st_reg.running && st_reg.countDown && (st_reg.count == '0);

  // count exceeds period only after period is lowered mid-count, so a larger compare otherwise never matches
  generate
    for (genvar i = 0; i < pfdc_pkg::NUM_OUT; i++) begin : g_match
      assign matchNow[i] = st_reg.running && (st_reg.count == st_reg.cmp[i]);
      assign chanCfg[i].forceSel = st_reg.forceSel[i];
      assign chanCfg[i].reflect = st_reg.reflect[i];
      assign chanCfg[i].stopLevel = st_reg.stopLevel[i];
    end
  endgenerate

  // ************************************************************
  // output channels
  // ************************************************************
  generate
    for (genvar i = 0; i < pfdc_pkg::NUM_OUT; i++) begin : g_chan
      pfdc_out_channel u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .running(st_reg.running),
        .startNow(startNow),
        .underflowNow(underflowNow),
        .matchNow(matchNow[i]),
        .cfg(chanCfg[i]),
        .pinOut(pinLevel[i]),
        .activeForce(activeForce[i])
      );
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  logic [pfdc_pkg::IRQ_W-1:0] irqSet;
  logic [pfdc_pkg::IRQ_W-1:0] irqClr;
  logic [pfdc_pkg::DATA_W-1:0] rdMux;

  always_comb begin
    st_next = st_reg;
    irqSet = '0;
    irqClr = '0;
    rdMux = '0;

    // register writes
    if (regWr) begin
      case (regAddr)
        pfdc_pkg::ADDR_CTRL: begin
          st_next.runReq = regWrData[pfdc_pkg::CTRL_RUN_BIT];
          st_next.stopLevel[0] = regWrData[pfdc_pkg::CTRL_STOP_A_BIT];
          st_next.stopLevel[1] = regWrData[pfdc_pkg::CTRL_STOP_B_BIT];
        end
        pfdc_pkg::ADDR_DUTY: begin
          // applied by the channels only at start or at underflow
          st_next.forceSel[0] = regWrData[pfdc_pkg::DUTY_A_FORCE_LSB +: 2];
          st_next.reflect[0] = regWrData[pfdc_pkg::DUTY_A_REFLECT_BIT];
          st_next.forceSel[1] = regWrData[pfdc_pkg::DUTY_B_FORCE_LSB +: 2];
          st_next.reflect[1] = regWrData[pfdc_pkg::DUTY_B_REFLECT_BIT];
        end
        pfdc_pkg::ADDR_PERIOD: begin
          st_next.period = regWrData[CNT_W-1:0];
        end
        pfdc_pkg::ADDR_CMP_A: begin
          st_next.cmp[0] = regWrData[CNT_W-1:0];
        end
        pfdc_pkg::ADDR_CMP_B: begin
          st_next.cmp[1] = regWrData[CNT_W-1:0];
        end
        pfdc_pkg::ADDR_IRQ_STAT: begin
          irqClr = regWrData[pfdc_pkg::IRQ_W-1:0];
        end
        pfdc_pkg::ADDR_IRQ_MASK: begin
          st_next.irqMask = regWrData[pfdc_pkg::IRQ_W-1:0];
        end
        default: begin
          st_next.runReq = st_reg.runReq;
        end
      endcase
    end

    // triangle counter; stopping returns it to the bottom
    if (!st_reg.runReq) begin
      st_next.running = 1'b0;
      st_next.countDown = 1'b0;
      st_next.count = '0;
    end else if (startNow) begin
      st_next.running = 1'b1;
      st_next.countDown = 1'b0;
      st_next.count = '0;
    end else if (st_reg.countDown) begin
      if (st_reg.count == '0) begin
        st_next.countDown = 1'b0;
        st_next.count = (st_reg.period == '0) ? st_reg.count : st_reg.count + 1'b1;
      end else begin
        st_next.count = st_reg.count - 1'b1;
      end
    end else begin
      if (st_reg.count >= st_reg.period) begin
        // peak reached, turn round; a zero period stays at the bottom
        st_next.countDown = 1'b1;
        st_next.count = (st_reg.count == '0) ? st_reg.count : st_reg.count - 1'b1;
      end else begin
        st_next.count = st_reg.count + 1'b1;
      end
    end

    // sticky status; a new event beats a clear in the same cycle
    irqSet[pfdc_pkg::IRQ_UNDERFLOW_BIT] = underflowNow;
    irqSet[pfdc_pkg::IRQ_MATCH_A_BIT] = matchNow[0];
    irqSet[pfdc_pkg::IRQ_MATCH_B_BIT] = matchNow[1];
    st_next.irqStat = (st_reg.irqStat & ~irqClr) | irqSet;
    st_next.irq = |(st_next.irqStat & st_next.irqMask);
    // raw pulse lets the handler retarget forcing for the next carrier
    st_next.underflowPulse = underflowNow;

    // read mux, answered in the following cycle only
    case (regAddr)
      pfdc_pkg::ADDR_CTRL: begin
        rdMux[pfdc_pkg::CTRL_RUN_BIT] = st_reg.runReq;
        rdMux[pfdc_pkg::CTRL_STOP_A_BIT] = st_reg.stopLevel[0];
        rdMux[pfdc_pkg::CTRL_STOP_B_BIT] = st_reg.stopLevel[1];
      end
      pfdc_pkg::ADDR_DUTY: begin
        rdMux[pfdc_pkg::DUTY_A_FORCE_LSB +: 2] = st_reg.forceSel[0];
        rdMux[pfdc_pkg::DUTY_A_REFLECT_BIT] = st_reg.reflect[0];
        rdMux[pfdc_pkg::DUTY_B_FORCE_LSB +: 2] = st_reg.forceSel[1];
        rdMux[pfdc_pkg::DUTY_B_REFLECT_BIT] = st_reg.reflect[1];
      end
      pfdc_pkg::ADDR_PERIOD: begin
        rdMux[CNT_W-1:0] = st_reg.period;
      end
      pfdc_pkg::ADDR_CMP_A: begin
        rdMux[CNT_W-1:0] = st_reg.cmp[0];
      end
      pfdc_pkg::ADDR_CMP_B: begin
        rdMux[CNT_W-1:0] = st_reg.cmp[1];
      end
      pfdc_pkg::ADDR_COUNT: begin
        rdMux[CNT_W-1:0] = st_reg.count;
      end
      pfdc_pkg::ADDR_IRQ_STAT: begin
        rdMux[pfdc_pkg::IRQ_W-1:0] = st_reg.irqStat;
      end
      pfdc_pkg::ADDR_IRQ_MASK: begin
        rdMux[pfdc_pkg::IRQ_W-1:0] = st_reg.irqMask;
      end
      pfdc_pkg::ADDR_STATUS: begin
        rdMux[pfdc_pkg::STAT_RUN_BIT] = st_reg.running;
        rdMux[pfdc_pkg::STAT_DOWN_BIT] = st_reg.countDown;
        rdMux[pfdc_pkg::STAT_PIN_A_BIT] = pinLevel[0];
        rdMux[pfdc_pkg::STAT_PIN_B_BIT] = pinLevel[1];
        rdMux[pfdc_pkg::STAT_ACT_A_LSB +: 2] = activeForce[0];
        rdMux[pfdc_pkg::STAT_ACT_B_LSB +: 2] = activeForce[1];
      end
      default: begin
        rdMux = '0;
      end
    endcase
    st_next.rdData = regRd ? rdMux : '0;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.period <= pfdc_pkg::RST_PERIOD[CNT_W-1:0];
      st_reg.cmp[0] <= pfdc_pkg::RST_CMP[CNT_W-1:0];
      st_reg.cmp[1] <= pfdc_pkg::RST_CMP[CNT_W-1:0];
      st_reg.irqMask <= pfdc_pkg::RST_IRQ_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output is a flop of this module or of a channel
  assign regRdData = st_reg.rdData;
  assign pwm_out_a = pinLevel[0];
  assign pwm_out_b = pinLevel[1];
  assign underflow_irq = st_reg.underflowPulse;
  assign irq = st_reg.irq;

endmodule : pfdc_forced_duty

// ### shared/pfdc_pkg.sv
package pfdc_pkg;

  // ************************************************************
  // bus geometry and register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W_DEF = 16;
  localparam int NUM_OUT = 2;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_A_BIT = 1;
  localparam int CTRL_STOP_B_BIT = 2;

  localparam int DUTY_A_FORCE_LSB = 0;
  localparam int DUTY_A_REFLECT_BIT = 2;
  localparam int DUTY_B_FORCE_LSB = 4;
  localparam int DUTY_B_REFLECT_BIT = 6;

  localparam int IRQ_W = 3;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_MATCH_A_BIT = 1;
  localparam int IRQ_MATCH_B_BIT = 2;

  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DOWN_BIT = 1;
  localparam int STAT_PIN_A_BIT = 2;
  localparam int STAT_PIN_B_BIT = 3;
  localparam int STAT_ACT_A_LSB = 4;
  localparam int STAT_ACT_B_LSB = 6;

  // ************************************************************
  // reset values and encodings
  // ************************************************************
  localparam logic [31:0] RST_PERIOD = 32'h0000FFFF;
  localparam logic [31:0] RST_CMP = 32'h00000000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_LOW = 2'h2;
  localparam logic [1:0] FORCE_HIGH = 2'h3;

  // per-output configuration carried to each output channel
  typedef struct packed {
    logic [1:0] forceSel;
    logic reflect;
    logic stopLevel;
  } pfdc_chan_cfg_s;

  // pin level from active forcing and the underlying compare level
  function automatic logic pfdc_pin_level(input logic [1:0] forceSel, input logic raw);
    logic lvl;
    lvl = raw;
    if (forceSel == FORCE_HIGH) begin
      lvl = 1'b1;
    end else if (forceSel == FORCE_LOW) begin
      lvl = 1'b0;
    end
    return lvl;
  endfunction : pfdc_pin_level

endpackage : pfdc_pkg

// ### design/pfdc_out_channel.sv
`timescale 1ns/1ps

module pfdc_out_channel (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic running,
  input wire logic startNow,
  input wire logic underflowNow,
  input wire logic matchNow,
  input wire pfdc_pkg::pfdc_chan_cfg_s cfg,
  output logic pinOut,
  output logic [1:0] activeForce
);

  // ************************************************************
  // channel state
  // ************************************************************
  typedef struct packed {
    logic raw;
    logic [1:0] active;
    logic pin;
  } pfdc_chan_state_s;

  pfdc_chan_state_s st_reg;
  pfdc_chan_state_s st_next;

  // compare level keeps toggling under a forced duty so release is seamless
  always_comb begin
    st_next = st_reg;
    if (startNow) begin
      st_next.raw = cfg.stopLevel;
      // only a forcing armed with the reflect flag survives into the count
      st_next.active = cfg.reflect ? cfg.forceSel : pfdc_pkg::FORCE_NONE;
    end else if (running) begin
      if (matchNow) begin
        st_next.raw = ~st_reg.raw;
      end
      if (underflowNow) begin
        st_next.active = cfg.forceSel;
      end
    end else begin
      st_next.raw = cfg.stopLevel;
      st_next.active = st_reg.active;
    end
    if (running || startNow) begin
      st_next.pin = pfdc_pkg::pfdc_pin_level(st_next.active, st_next.raw);
    end else begin
      st_next.pin = cfg.stopLevel;
    end
  end

  // state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinOut = st_reg.pin;
  assign activeForce = st_reg.active;

endmodule : pfdc_out_channel

// ### testbench/pfdc_forced_duty_properties.sv
`timescale 1ns/1ps
// judges the pins against software writes seen on the bus
module pfdc_checker #(
  parameter int CNT_W = pfdc_pkg::CNT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic underflow_irq,
  input wire logic irq
);
  logic runS, stopA, stopB, seenUf;
  logic [6:0] dutyS, ufDuty;
  logic [CNT_W-1:0] perS;
  logic [CNT_W+1:0] gap;

  // shadow copies, so no internal state is needed to judge pins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {runS, stopA, stopB, seenUf} <= 4'h0;
      dutyS <= 7'h00;
      ufDuty <= 7'h00;
      perS <= '1;
      gap <= '0;
    end else begin
      if (regWr && regAddr == pfdc_pkg::ADDR_CTRL) begin
        {stopB, stopA, runS} <= regWrData[2:0];
      end
      if (regWr && regAddr == pfdc_pkg::ADDR_DUTY) begin
        dutyS <= regWrData[6:0];
      end
      if (regWr && regAddr == pfdc_pkg::ADDR_PERIOD) begin
        perS <= regWrData[CNT_W-1:0];
      end
      // forcing in effect for the carrier that just began
      if (underflow_irq) begin
        ufDuty <= dutyS;
      end
      gap <= underflow_irq ? '0 : gap + 1'b1;
      seenUf <= runS && (seenUf || underflow_irq);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  carrier_len_a: assert property (underflow_irq && seenUf |-> int'(gap) + 1 == 2 * int'(perS))
    else $error("carrier length off");
  arm_start_a: assert property ($rose(runS) && dutyS[2] && dutyS[1] |=> pwm_out_a == dutyS[0])
    else $error("pin a not forced at start");
  arm_b_a: assert property ($rose(runS) && dutyS[6] && dutyS[5] |=> pwm_out_b == dutyS[4])
    else $error("pin b not forced at start");
  unarmed_start_a: assert property ($rose(runS) && !dutyS[2] |=> pwm_out_a == stopA)
    else $error("unarmed forcing applied at start");
  carrier_force_a: assert property ($past(underflow_irq) && runS && ufDuty[1]
    |-> (pwm_out_a == ufDuty[0]) [*3])
    else $error("pin a forcing not held");
  carrier_b_a: assert property ($past(underflow_irq) && runS && ufDuty[5]
    |-> (pwm_out_b == ufDuty[4]) [*3])
    else $error("pin b forcing not held");
  // the channel flop needs two edges after the run bit falls to see the counter idle
  stop_level_a: assert property (!runS && !$past(runS) && !$past(runS, 2) && $stable({stopA, stopB})
    |-> {pwm_out_b, pwm_out_a} == {stopB, stopA})
    else $error("stopped pins not at stop level");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read slot");

  cover property ($rose(runS) && dutyS[2]);
  cover property ($past(underflow_irq) && ufDuty[1]);
  cover property (irq);
endmodule : pfdc_checker

bind pfdc_forced_duty pfdc_checker #(.CNT_W(CNT_W)) chk (.ref_clk(ref_clk), .nrst(nrst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
  .underflow_irq(underflow_irq), .irq(irq));

// ### testbench/test_pfdc_forced_duty.sv
`timescale 1ns/1ps
// drives the bus by hand, period 4 keeps a carrier at 8 cycles
module test_pfdc_forced_duty;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic pwmA, pwmB, ufIrq, irq;
  int errTotal = 0;
  int checksDone = 0;

  // 200 MHz
  always #2.5 ref_clk = ~ref_clk;

  pfdc_forced_duty #(.CNT_W(8)) uut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pwm_out_a(pwmA), .pwm_out_b(pwmB), .underflow_irq(ufIrq), .irq(irq));

  task automatic give_verdict();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one idle cycle after each access, so strobes never retoggle in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge ref_clk);
  endtask : rd

  task automatic look(input logic e);
    @(posedge ref_clk);
    #1 chk({31'h0, irq}, {31'h0, e});
    @(posedge ref_clk);
  endtask : look

  task automatic hold(input logic ea, input logic eb, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1 chk({30'h0, pwmB, pwmA}, {30'h0, eb, ea});
    end
    @(posedge ref_clk);
  endtask : hold

  // high cycles over two carriers, independent of phase
  task automatic duty(input int ea, input int eb);
    int ca, cb;
    ca = 0;
    cb = 0;
    repeat (16) begin
      @(posedge ref_clk);
      #1 ca += int'(pwmA === 1'b1);
      cb += int'(pwmB === 1'b1);
    end
    chk(32'(ca), 32'(ea));
    chk(32'(cb), 32'(eb));
    @(posedge ref_clk);
  endtask : duty

  // bounded wait for the underflow pulse
  task automatic wait_uf();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (ufIrq !== 1'b1 && n < 100);
    if (n >= 100) begin
      errTotal++;
      give_verdict();
    end
    @(posedge ref_clk);
  endtask : wait_uf

  task automatic s_regs();
    // bench counter is 8 bits wide, so only the low byte of the reset period survives
    rd(pfdc_pkg::ADDR_PERIOD, {24'h000000, pfdc_pkg::RST_PERIOD[7:0]});
    rd(pfdc_pkg::ADDR_CMP_A, pfdc_pkg::RST_CMP);
    rd(8'h3C, 32'h0);
    wr(pfdc_pkg::ADDR_PERIOD, 32'h4);
    rd(pfdc_pkg::ADDR_PERIOD, 32'h4);
  endtask : s_regs

  // armed start, rewrites right after the first two underflows, events while forced
  task automatic s_forced();
    wr(pfdc_pkg::ADDR_CMP_A, 32'h1);
    wr(pfdc_pkg::ADDR_CMP_B, 32'h2);
    wr(pfdc_pkg::ADDR_CTRL, 32'h4);
    hold(1'b0, 1'b1, 2);
    wr(pfdc_pkg::ADDR_DUTY, 32'h76);
    wr(pfdc_pkg::ADDR_CTRL, 32'h5);
    hold(1'b0, 1'b1, 6);
    wait_uf();
    wr(pfdc_pkg::ADDR_DUTY, 32'h23);
    hold(1'b0, 1'b1, 3);
    wait_uf();
    wr(pfdc_pkg::ADDR_DUTY, 32'h32);
    hold(1'b1, 1'b0, 3);
    wait_uf();
    hold(1'b0, 1'b1, 4);
    rd(pfdc_pkg::ADDR_IRQ_STAT, 32'h7);
    look(1'b0);
    wr(pfdc_pkg::ADDR_IRQ_MASK, 32'h2);
    look(1'b1);
    wr(pfdc_pkg::ADDR_CTRL, 32'h6);
    hold(1'b1, 1'b1, 2);
    wr(pfdc_pkg::ADDR_IRQ_STAT, 32'h7);
    rd(pfdc_pkg::ADDR_IRQ_STAT, 32'h0);
    look(1'b0);
  endtask : s_forced

  // forcing changed while stopped without the start flag
  task automatic s_unarmed();
    wr(pfdc_pkg::ADDR_DUTY, 32'h02);
    wr(pfdc_pkg::ADDR_CMP_A, 32'h5);
    wr(pfdc_pkg::ADDR_CMP_B, 32'h5);
    wr(pfdc_pkg::ADDR_CTRL, 32'h3);
    hold(1'b1, 1'b0, 5);
    wait_uf();
    hold(1'b0, 1'b0, 4);
    wr(pfdc_pkg::ADDR_CTRL, 32'h0);
  endtask : s_unarmed

  // codes 00 and 01 leave compare control; edge compare values
  task automatic s_normal();
    wr(pfdc_pkg::ADDR_DUTY, 32'h10);
    wr(pfdc_pkg::ADDR_CMP_A, 32'h1);
    wr(pfdc_pkg::ADDR_CTRL, 32'h1);
    duty(12, 0);
    wr(pfdc_pkg::ADDR_CMP_A, 32'h0);
    wr(pfdc_pkg::ADDR_CMP_B, 32'h4);
    duty(8, 8);
    wr(pfdc_pkg::ADDR_CTRL, 32'h0);
  endtask : s_normal

  // reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    s_regs();
    s_forced();
    s_unarmed();
    s_normal();
    give_verdict();
  end
endmodule : test_pfdc_forced_duty
